// >>> pkg/urxu_pkg.sv
/*
  urxu_pkg: register offsets, field positions, reset values and codes
  shared by the receive-unload channel block and its fifo.
  assumes byte-addressed register accesses on a 9-bit offset.
*/
package urxu_pkg;
  // per-channel register offsets
  localparam logic [8:0] OFS_DATA = 9'h000;
  localparam logic [8:0] OFS_IER = 9'h001;
  localparam logic [8:0] OFS_ISR = 9'h002;
  localparam logic [8:0] OFS_LCR = 9'h003;
  localparam logic [8:0] OFS_MCR = 9'h004;
  localparam logic [8:0] OFS_LSR = 9'h005;
  localparam logic [8:0] OFS_MSR = 9'h006;
  localparam logic [8:0] OFS_SPR = 9'h007;
  localparam logic [8:0] OFS_FEATURE_CONTROL = 9'h008;
  localparam logic [8:0] OFS_EFR = 9'h009;
  localparam logic [8:0] OFS_TXLVL = 9'h00a;
  localparam logic [8:0] OFS_RXLVL = 9'h00b;
  localparam logic [8:0] OFS_FLOW_CHAR_STATUS = 9'h00c;
  localparam logic [8:0] OFS_RESUME_CHAR_ONE = 9'h010;
  localparam logic [8:0] OFS_RESUME_CHAR_TWO = 9'h011;
  localparam logic [8:0] OFS_PAUSE_CHAR_ONE = 9'h012;
  localparam logic [8:0] OFS_PAUSE_CHAR_TWO = 9'h013;
  // device-wide offsets
  localparam logic [8:0] OFS_GINT0 = 9'h080;
  localparam logic [8:0] OFS_GINT1 = 9'h081;
  localparam logic [8:0] OFS_GINT2 = 9'h082;
  localparam logic [8:0] OFS_GINT3 = 9'h083;
  localparam logic [8:0] OFS_DEVICE_IDENTIFICATION_D = 9'h08c;
  localparam logic [8:0] OFS_DEVICE_IDENTIFICATION_B = 9'h08d;
  localparam logic [8:0] OFS_SPECIAL = 9'h180;
  // field positions
  localparam int LCR_DLAB = 7;
  localparam int IER_RXDATA = 0;
  localparam int FCR_FIFO_EN = 0;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int LSR_DR = 0;
  localparam int LSR_THRE = 5;
  localparam int LSR_TEMT = 6;
  localparam int LSR_ERR = 7;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_SPR = 8'hff;
  localparam logic [7:0] RST_ISR = 8'h01;
  localparam logic [7:0] RST_LSR = 8'h60;
  // interrupt status codes and limits
  localparam logic [7:0] ISR_NONE = 8'h01;
  localparam logic [7:0] ISR_RXDATA = 8'h04;
  localparam logic [7:0] TRIG_MAX = 8'h40;
  // fifo entry: data in [7:0], error flags in [11:8]
  localparam int ENTRY_W = 12;
  localparam int FIFO_DEPTH = 8;
endpackage

// >>> hw/urxu_sync.sv
/*
  urxu_sync: two-flop synchroniser for a group of pin levels.
  assumes the pins are static long enough to be seen; no reset so that
  pin levels are followed while the chip reset is still asserted.
*/
`timescale 1ns/100ps
`default_nettype none
module urxu_sync #(
  parameter int WIDTH = 5
) (
  // clock
  input wire logic i_clock,
  // pins in, levels out
  input wire logic [WIDTH-1:0] i_pins,
  output logic [WIDTH-1:0] o_levels
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } urxu_sync_t;

  urxu_sync_t s;
  urxu_sync_t next_s;

  // first stage feeds only the second
  always_comb begin
    next_s = s;
    next_s.stage1 = i_pins;
    next_s.stage2 = s.stage1;
  end

  always_ff @(posedge i_clock) begin
    s <= next_s;
  end

  assign o_levels = s.stage2;
endmodule // urxu_sync
`default_nettype wire

// >>> hw/urxu_fifo.sv
/*
  urxu_fifo: receive fifo with valid/ready on both sides and a level count.
  assumes one clock; depth a power of two.
*/
`timescale 1ns/100ps
`default_nettype none
module urxu_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic [$clog2(DEPTH):0] o_level
);
  localparam int AW = $clog2(DEPTH);

  // wrapping pointers only work for a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
    $error("fifo depth must be a power of two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] level;
  } urxu_fifo_t;

  urxu_fifo_t s;
  urxu_fifo_t next_s;
  logic push;
  logic pop;

  // honest full and empty from the level count
  assign o_in_ready = (s.level != (AW+1)'(DEPTH));
  assign o_out_valid = (s.level != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = i_out_ready && o_out_valid;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr_ptr] = i_in_data;
      next_s.wr_ptr = s.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_s.rd_ptr = s.rd_ptr + 1'b1;
    end
    next_s.level = s.level + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_out_data = s.mem[s.rd_ptr];
  assign o_level = s.level;
endmodule // urxu_fifo
`default_nettype wire

// >>> hw/urxu_channel.sv
/*
  urxu_channel: one serial channel's register set with the receive unload
  path, device id and global interrupt words.
  assumes a byte register port with one-cycle read and write strobes from
  the bus target, and a receive deserializer on the same clock.
*/
// Contract
// - receive threshold write sets a level from zero to sixty-four.
// - receive interrupt raised once fifo level reaches the threshold and is above zero.
// - reset values: isr 01, lsr 60, scratch ff, others zero.
// - modem status change bits clear on reset, upper bits follow inputs.
// - transmit output idles high unless infrared enable pin is high.
// - rts and dtr high, eeprom clock, select, data low at reset.
// - after id read, combined reads stay ordered until another register access.
// - device id readable at 0x8d byte or 0x8c dword offset.
// - combined read returns one character with its line status byte.
// - global interrupt words at 0x080 and 0x081 show the channel's pending interrupt; 0x082 and 0x083 read zero.
// - channel interrupt status register shows the interrupt source.
`timescale 1ns/100ps
`default_nettype none
module urxu_channel #(
  parameter logic [7:0] DEVICE_ID = 8'h5a, // arbitrary value
  parameter int DEPTH = urxu_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // register port
  input wire logic [8:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // receive stream from the deserializer
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic [3:0] i_rx_error,
  output logic o_rx_ready,
  // modem and strap pins
  input wire logic i_cts_n,
  input wire logic i_dsr_n,
  input wire logic i_ri_n,
  input wire logic i_cd_n,
  input wire logic i_infrared_enable_pin,
  // serial, handshake, eeprom and unload-armed outputs
  output logic o_tx,
  output logic o_rts_n,
  output logic o_dtr_n,
  output logic o_eeprom_serial_clock,
  output logic o_eeprom_chip_select,
  output logic o_eeprom_serial_data_in,
  output logic o_unload_armed
);
  localparam int LW = $clog2(DEPTH) + 1;

  if (DEPTH > 64) begin : g_depth_check
    $error("receive fifo deeper than the level count can show");
  end

  typedef struct packed {
    logic [7:0] dll;
    logic [7:0] baud_divisor_high;
    logic [7:0] transmit_holding;
    logic [7:0] interrupt_enable;
    logic [7:0] fifo_control;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] scratch_pad;
    logic [7:0] feature_control;
    logic [7:0] enhanced_features;
    logic [7:0] tx_threshold;
    logic [7:0] rx_threshold;
    logic [7:0] resume_char_one;
    logic [7:0] resume_char_two;
    logic [7:0] pause_char_one;
    logic [7:0] pause_char_two;
    logic [3:0] msr_delta;
    logic [3:0] msr_prev;
    logic primed;
    logic armed;
    logic [15:0] rdata;
    logic rvalid;
    logic [2:0] eeprom;
  } urxu_channel_t;

  urxu_channel_t s;
  urxu_channel_t next_s;

  logic [4:0] pin_levels;
  logic [3:0] modem_levels;
  logic ir_level;
  logic fifo_valid;
  logic fifo_pop;
  logic [urxu_pkg::ENTRY_W-1:0] fifo_head;
  logic [LW-1:0] fifo_level;
  logic [7:0] rx_level;
  logic [7:0] line_status;
  logic [7:0] interrupt_status;
  logic rx_int;
  logic dlab;
  logic [15:0] rd_val;
  logic is_device_identification;
  logic is_special;

  // pins cross in through two flops
  urxu_sync #(.WIDTH(5)) u_sync (
    .i_clock(i_clock),
    .i_pins({i_infrared_enable_pin, i_cd_n, i_ri_n, i_dsr_n, i_cts_n}),
    .o_levels(pin_levels)
  );
  assign ir_level = pin_levels[4];
  assign modem_levels = ~pin_levels[3:0]; // cd, ri, dsr, cts as asserted

  // receive buffer; its ready stalls the deserializer
  urxu_fifo #(.WIDTH(urxu_pkg::ENTRY_W), .DEPTH(DEPTH)) u_fifo (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_in_valid(i_rx_valid),
    .o_in_ready(o_rx_ready),
    .i_in_data({i_rx_error, i_rx_data}),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_head),
    .o_level(fifo_level)
  );
  assign rx_level = 8'(fifo_level);

  // line status from the fifo head; empty fifo gives the reset value
  always_comb begin
    line_status = urxu_pkg::RST_LSR;
    line_status[urxu_pkg::LSR_DR] = fifo_valid;
    if (fifo_valid) begin
      line_status[4:1] = fifo_head[11:8];
      line_status[urxu_pkg::LSR_ERR] = |fifo_head[11:8];
    end
  end

  // receive interrupt once the level has climbed to the threshold and above zero
  assign rx_int = s.interrupt_enable[urxu_pkg::IER_RXDATA] && fifo_valid && (rx_level >= s.rx_threshold);
  always_comb begin
    interrupt_status = rx_int ? urxu_pkg::ISR_RXDATA : urxu_pkg::ISR_NONE;
    interrupt_status[7:6] = {2{s.fifo_control[urxu_pkg::FCR_FIFO_EN]}};
  end

  assign dlab = s.line_control[urxu_pkg::LCR_DLAB];
  assign is_device_identification = (i_reg_addr == urxu_pkg::OFS_DEVICE_IDENTIFICATION_B) || (i_reg_addr == urxu_pkg::OFS_DEVICE_IDENTIFICATION_D);
  assign is_special = (i_reg_addr == urxu_pkg::OFS_SPECIAL);
  // a pop on the combined register or plain holding register
  assign fifo_pop = i_reg_rd && fifo_valid && (is_special || (i_reg_addr == urxu_pkg::OFS_DATA && !dlab));

  // read multiplexer; write-only registers share offsets with counters
  always_comb begin
    rd_val = 16'h0000;
    case (i_reg_addr)
      urxu_pkg::OFS_DATA: rd_val[7:0] = dlab ? s.dll : fifo_head[7:0];
      urxu_pkg::OFS_IER: rd_val[7:0] = dlab ? s.baud_divisor_high : s.interrupt_enable;
      urxu_pkg::OFS_ISR: rd_val[7:0] = interrupt_status;
      urxu_pkg::OFS_LCR: rd_val[7:0] = s.line_control;
      urxu_pkg::OFS_MCR: rd_val[7:0] = s.modem_control;
      urxu_pkg::OFS_LSR: rd_val[7:0] = line_status;
      urxu_pkg::OFS_MSR: rd_val[7:0] = {modem_levels, s.msr_delta};
      urxu_pkg::OFS_SPR: rd_val[7:0] = s.scratch_pad;
      urxu_pkg::OFS_FEATURE_CONTROL: rd_val[7:0] = s.feature_control;
      urxu_pkg::OFS_EFR: rd_val[7:0] = s.enhanced_features;
      urxu_pkg::OFS_TXLVL: rd_val[7:0] = 8'h00; // no transmitter, always empty
      urxu_pkg::OFS_RXLVL: rd_val[7:0] = rx_level;
      urxu_pkg::OFS_RESUME_CHAR_ONE: rd_val[7:0] = s.resume_char_one;
      urxu_pkg::OFS_RESUME_CHAR_TWO: rd_val[7:0] = s.resume_char_two;
      urxu_pkg::OFS_PAUSE_CHAR_ONE: rd_val[7:0] = s.pause_char_one;
      urxu_pkg::OFS_PAUSE_CHAR_TWO: rd_val[7:0] = s.pause_char_two;
      urxu_pkg::OFS_GINT0: rd_val[7:0] = {7'h00, ~interrupt_status[0]};
      urxu_pkg::OFS_GINT1: rd_val[7:0] = {5'h00, interrupt_status[3:1]};
      urxu_pkg::OFS_DEVICE_IDENTIFICATION_B: rd_val[7:0] = DEVICE_ID;
      urxu_pkg::OFS_DEVICE_IDENTIFICATION_D: rd_val[7:0] = DEVICE_ID;
      urxu_pkg::OFS_SPECIAL: rd_val = {line_status, fifo_head[7:0]};
      default: rd_val = 16'h0000;
    endcase
  end

  // register writes, read side effects and modem change tracking
  always_comb begin
    next_s = s;
    next_s.rvalid = i_reg_rd;
    if (i_reg_rd) begin
      next_s.rdata = rd_val;
    end
    // id access arms ordered unloading; any access except the combined register disarms it
    if ((i_reg_rd || i_reg_wr) && is_device_identification) begin
      next_s.armed = 1'b1;
    end else if ((i_reg_rd || i_reg_wr) && !is_special) begin
      next_s.armed = 1'b0;
    end
    if (i_reg_wr) begin
      case (i_reg_addr)
        urxu_pkg::OFS_DATA: begin
          if (dlab) next_s.dll = i_reg_wdata;
          else next_s.transmit_holding = i_reg_wdata;
        end
        urxu_pkg::OFS_IER: begin
          if (dlab) next_s.baud_divisor_high = i_reg_wdata;
          else next_s.interrupt_enable = i_reg_wdata;
        end
        urxu_pkg::OFS_ISR: next_s.fifo_control = i_reg_wdata;
        urxu_pkg::OFS_LCR: next_s.line_control = i_reg_wdata;
        urxu_pkg::OFS_MCR: next_s.modem_control = i_reg_wdata;
        urxu_pkg::OFS_SPR: next_s.scratch_pad = i_reg_wdata;
        urxu_pkg::OFS_FEATURE_CONTROL: next_s.feature_control = i_reg_wdata;
        urxu_pkg::OFS_EFR: next_s.enhanced_features = i_reg_wdata;
        urxu_pkg::OFS_TXLVL: begin
          next_s.tx_threshold = (i_reg_wdata > urxu_pkg::TRIG_MAX) ? urxu_pkg::TRIG_MAX : i_reg_wdata;
        end
        urxu_pkg::OFS_RXLVL: begin
          // values above sixty-four saturate at sixty-four
          next_s.rx_threshold = (i_reg_wdata > urxu_pkg::TRIG_MAX) ? urxu_pkg::TRIG_MAX : i_reg_wdata;
        end
        urxu_pkg::OFS_RESUME_CHAR_ONE: next_s.resume_char_one = i_reg_wdata;
        urxu_pkg::OFS_RESUME_CHAR_TWO: next_s.resume_char_two = i_reg_wdata;
        urxu_pkg::OFS_PAUSE_CHAR_ONE: next_s.pause_char_one = i_reg_wdata;
        urxu_pkg::OFS_PAUSE_CHAR_TWO: next_s.pause_char_two = i_reg_wdata;
        default: next_s.pause_char_two = s.pause_char_two;
      endcase
    end
    // read clears change bits, a change in the same cycle still sets them
    if (i_reg_rd && i_reg_addr == urxu_pkg::OFS_MSR) begin
      next_s.msr_delta = 4'h0;
    end
    if (s.primed) begin
      next_s.msr_delta = next_s.msr_delta | ({modem_levels[3:1], modem_levels[0]} ^ s.msr_prev);
    end
    // first cycle after reset only learns the levels, no false change
    next_s.msr_prev = modem_levels;
    next_s.primed = 1'b1;
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s <= '0;
      s.scratch_pad <= urxu_pkg::RST_SPR;
    end else begin
      s <= next_s;
    end
  end

  // outputs; tx follows the strap so it is right even during reset
  assign o_tx = ~ir_level;
  assign o_rts_n = ~s.modem_control[urxu_pkg::MCR_RTS];
  assign o_dtr_n = ~s.modem_control[urxu_pkg::MCR_DTR];
  assign o_eeprom_serial_clock = s.eeprom[0];
  assign o_eeprom_chip_select = s.eeprom[1];
  assign o_eeprom_serial_data_in = s.eeprom[2];
  assign o_reg_rdata = s.rdata;
  assign o_reg_rvalid = s.rvalid;
  assign o_unload_armed = s.armed;

  // checks
  sequence seq_special_rd;
    i_reg_rd && is_special && fifo_valid;
  endsequence
  sequence seq_device_identification_rd;
    i_reg_rd && is_device_identification;
  endsequence
  sequence seq_no_access;
    !(i_reg_rd || i_reg_wr);
  endsequence

  AST_RX_THRESHOLD_WRITE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_reg_wr && i_reg_addr == urxu_pkg::OFS_RXLVL |=>
    s.rx_threshold == (($past(i_reg_wdata) > 8'h40) ? 8'h40 : $past(i_reg_wdata)))
    else $error("rx threshold not taken");
  AST_RX_INT: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    s.interrupt_enable[0] && fifo_valid && rx_level >= s.rx_threshold |-> interrupt_status[3:0] == 4'h4) else $error("rx interrupt missing");
  AST_RESET_VALUES: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    $rose(i_arst_n) |-> s.scratch_pad == 8'hff && s.interrupt_enable == 8'h00 && s.rx_threshold == 8'h00 && s.line_control == 8'h00)
    else $error("bad reset values");
  AST_MSR_READ: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_reg_rd && i_reg_addr == urxu_pkg::OFS_MSR |=> o_reg_rdata[7:4] == $past(modem_levels))
    else $error("modem levels wrong");
  AST_HANDSHAKE_IDLE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    s.modem_control[1:0] == 2'b00 |-> o_rts_n && o_dtr_n && !o_eeprom_serial_clock) else $error("handshake not idle");
  AST_DEVICE_IDENTIFICATION_READ: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    seq_device_identification_rd |=> o_reg_rvalid && o_reg_rdata[7:0] == DEVICE_ID && o_unload_armed) else $error("id read wrong");
  AST_SPECIAL_READ: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    seq_special_rd |=> o_reg_rvalid && o_reg_rdata[8] && o_reg_rdata[7:0] == $past(fifo_head[7:0]))
    else $error("combined read wrong");
  AST_POP_LEVEL: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    seq_special_rd ##0 !(i_rx_valid && o_rx_ready) |=> rx_level == $past(rx_level) - 8'h01)
    else $error("level not lowered");
  AST_ARMED_HOLD: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    seq_device_identification_rd ##1 seq_no_access ##1 seq_special_rd |=> o_unload_armed) else $error("unload disarmed");
  AST_GLOBAL_INT: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_reg_rd && i_reg_addr == urxu_pkg::OFS_GINT0 |=> o_reg_rdata[0] == $past(rx_int)) else $error("global int wrong");
  AST_ISR_READ: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_reg_rd && i_reg_addr == urxu_pkg::OFS_ISR |=> o_reg_rdata[7:0] == $past(interrupt_status)) else $error("isr read wrong");
endmodule // urxu_channel
`default_nettype wire

// >>> test/urxu_rx_source.sv
/*
  urxu_rx_source: model of the receive deserializer feeding the channel.
  assumes the channel takes a character at a rising edge with valid and ready.
*/
`timescale 1ns/100ps
`default_nettype none
module urxu_rx_source (
  // clock
  input wire logic i_clock,
  // stream to the channel
  input wire logic i_ready,
  output logic o_valid,
  output logic [7:0] o_data,
  output logic [3:0] o_error
);
  logic [11:0] pend[$];
  logic took;
  initial begin
    o_valid = 1'b0;
    o_data = 8'h00;
    o_error = 4'h0;
    took = 1'b0;
  end
  // queue a character with its error flags
  task automatic send(input logic [7:0] d, input logic [3:0] e);
    pend.push_back({e, d});
  endtask
  // note whether the last edge took the offer
  always @(posedge i_clock) begin
    took <= o_valid & i_ready;
  end
  // offer held until taken; idle data flips so stale values never match
  always @(negedge i_clock) begin
    if (!o_valid || took) begin
      if (pend.size() > 0) begin
        {o_error, o_data} = pend.pop_front();
        o_valid = 1'b1;
      end else begin
        o_valid = 1'b0;
        o_data = ~o_data;
        o_error = ~o_error;
      end
    end
  end
endmodule // urxu_rx_source
`default_nettype wire

// >>> test/test_urxu_channel.sv
/*
  test_urxu_channel: self-checking bench for the receive-unload channel.
  assumes the register port contract: one-cycle strobes, rvalid one cycle later.
*/
`timescale 1ns/100ps
`default_nettype none
module test_urxu_channel;
  localparam logic [7:0] ID = 8'h3c; // arbitrary value
  logic i_clock, i_arst_n, i_reg_rd, i_reg_wr, rx_valid, rx_ready, o_reg_rvalid, o_tx;
  logic i_cts_n, i_dsr_n, i_ri_n, i_cd_n, i_ir, o_rts_n, o_dtr_n, o_ck, o_cs, o_di, o_armed;
  logic [8:0] i_reg_addr;
  logic [7:0] i_reg_wdata, rx_data;
  logic [3:0] rx_error;
  logic [15:0] o_reg_rdata, rd_val;
  int error_cnt, compares;
  // reset-value table: offset and expected low byte
  localparam logic [8:0] RA [0:14] = '{9'h001, 9'h002, 9'h003, 9'h004, 9'h005, 9'h007, 9'h008,
    9'h009, 9'h00a, 9'h00b, 9'h00c, 9'h010, 9'h011, 9'h012, 9'h013};
  localparam logic [7:0] RV [0:14] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'hff, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  urxu_channel #(.DEVICE_ID(ID)) urxu_channel_i (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_rx_valid(rx_valid),
    .i_rx_data(rx_data), .i_rx_error(rx_error), .o_rx_ready(rx_ready), .i_cts_n(i_cts_n),
    .i_dsr_n(i_dsr_n), .i_ri_n(i_ri_n), .i_cd_n(i_cd_n), .i_infrared_enable_pin(i_ir),
    .o_tx(o_tx), .o_rts_n(o_rts_n), .o_dtr_n(o_dtr_n), .o_eeprom_serial_clock(o_ck),
    .o_eeprom_chip_select(o_cs), .o_eeprom_serial_data_in(o_di), .o_unload_armed(o_armed));
  urxu_rx_source urxu_rx_source_i (.i_clock(i_clock), .i_ready(rx_ready), .o_valid(rx_valid),
    .o_data(rx_data), .o_error(rx_error));

  // free-running 25 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // one read: strobe for one cycle, data taken while rvalid stands
  task automatic rd(input logic [8:0] a);
    @(negedge i_clock);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    @(negedge i_clock);
    i_reg_rd = 1'b0;
    chk(16'(o_reg_rvalid), 16'h0001, "read answer");
    rd_val = o_reg_rdata;
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge i_clock);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_clock);
    i_reg_wr = 1'b0;
  endtask
  // reset with a strap level; pins checked while reset still holds
  task automatic do_reset(input logic ir);
    @(negedge i_clock);
    i_ir = ir;
    i_arst_n = 1'b0;
    repeat (12) @(negedge i_clock);
    chk(16'(o_tx), {15'h0000, ~ir}, "tx idle");
    chk(16'({o_rts_n, o_dtr_n, o_ck, o_cs, o_di}), 16'h0018, "reset pins");
    i_arst_n = 1'b1;
  endtask

  task automatic t_reset;
    wr(9'h004, 8'h03);
    chk(16'({o_rts_n, o_dtr_n}), 16'h0000, "handshake on");
    do_reset(1'b1); // outputs must fall back even after mcr was set
    do_reset(1'b0);
    for (int k = 0; k < 15; k++) begin
      rd(RA[k]);
      chk(rd_val, {8'h00, RV[k]}, "reset value");
    end
    rd(9'h006);
    chk(rd_val, 16'h0010, "modem status at reset");
    i_dsr_n = 1'b0;
    repeat (4) @(negedge i_clock);
    rd(9'h006);
    chk(rd_val, 16'h0032, "modem status change");
    rd(9'h1ff);
    chk(rd_val, 16'h0000, "unmapped read");
    // divisor latch access and fifo enable in the status high bits
    wr(9'h003, 8'h80);
    wr(9'h000, 8'h12);
    wr(9'h001, 8'h34);
    rd(9'h000);
    chk(rd_val, 16'h0012, "divisor low");
    rd(9'h001);
    chk(rd_val, 16'h0034, "divisor high");
    wr(9'h003, 8'h00);
    wr(9'h002, 8'h01);
    rd(9'h002);
    chk(rd_val, 16'h00c1, "fifo enable in isr");
    wr(9'h002, 8'h00);
    $display("test reset done");
  endtask

  // threshold of three: interrupt only once the third character lands
  task automatic t_trigger;
    wr(9'h001, 8'h01);
    wr(9'h00b, 8'h00);
    rd(9'h002);
    chk(rd_val, 16'h0001, "empty, threshold zero");
    wr(9'h00b, 8'h03);
    for (int k = 0; k < 2; k++) urxu_rx_source_i.send(8'h41 + 8'(k), 4'(k));
    repeat (6) @(negedge i_clock);
    rd(9'h002);
    chk(rd_val, 16'h0001, "below threshold");
    urxu_rx_source_i.send(8'h43, 4'h2);
    repeat (4) @(negedge i_clock);
    rd(9'h002);
    chk(rd_val, 16'h0004, "at threshold");
    rd(9'h080);
    chk(rd_val, 16'h0001, "global source");
    rd(9'h081);
    chk(rd_val, 16'h0002, "channel word");
    wr(9'h00b, 8'h50); // above 64 saturates, never reached with eight entries
    rd(9'h002);
    chk(rd_val, 16'h0001, "high threshold");
    $display("test trigger done");
  endtask

  // fill to refusal, then unload with the id read discipline
  task automatic t_unload;
    int n;
    n = 0;
    for (int k = 3; k < 9; k++) urxu_rx_source_i.send(8'h41 + 8'(k), 4'(k));
    repeat (12) @(negedge i_clock);
    chk(16'(rx_ready), 16'h0000, "fifo full refuses");
    rd(9'h08d);
    chk(rd_val, {8'h00, ID}, "id byte");
    chk(16'(o_armed), 16'h0001, "armed");
    rd(9'h180);
    chk(rd_val, {3'h3, 4'h0, 1'b1, 8'h41}, "first char");
    rd(9'h00b);
    chk(rd_val, 16'h0008, "level after pop and refill");
    chk(16'(o_armed), 16'h0000, "disarmed by other access");
    rd(9'h08c);
    chk(rd_val, {8'h00, ID}, "id dword");
    n = 1;
    rd(9'h180);
    while (rd_val[8] === 1'b1 && n < 12) begin
      chk(rd_val[12:0], {4'(n), 1'b1, 8'h41 + 8'(n)}, "char order");
      n++;
      rd(9'h180);
    end
    chk(16'(n), 16'h0009, "chars unloaded");
    chk(16'(o_armed), 16'h0001, "still armed");
    rd(9'h00b);
    chk(rd_val, 16'h0000, "level empty");
    $display("test unload done");
  endtask

  task automatic close_out;
    $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge i_clock);
    error_cnt++;
    $display("FAIL at %0t: watchdog expired", $time);
    close_out();
  end

  initial begin
    error_cnt = 0;
    compares = 0;
    i_arst_n = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_wr = 1'b0;
    i_reg_addr = 9'h000;
    i_reg_wdata = 8'h00;
    {i_cd_n, i_ri_n, i_dsr_n, i_cts_n} = 4'he;
    i_ir = 1'b0;
    repeat (12) @(negedge i_clock);
    i_arst_n = 1'b1;
    t_reset();
    t_trigger();
    t_unload();
    close_out();
  end
endmodule // test_urxu_channel
`default_nettype wire
